/* hw/pwm_pkg.sv */
// Package: register map, field layout, reset values and types of the pulse modulator
package pwm_pkg;

   // ----------------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------------
   localparam int unsigned NUM_CMP    = 8;     // Match comparators
   localparam int unsigned NUM_OUT    = 8;     // Modulated outputs
   localparam int unsigned CNT_W      = 16;    // Shared counter width
   localparam int unsigned PRE_W      = 8;     // Prescaler width
   localparam int unsigned REP_W      = 8;     // Repetition count width

   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00; // Enables, trigger mode, block reset
   localparam logic [7:0] OFS_STATUS  = 8'h04; // Running state, completion flag (W1C)
   localparam logic [7:0] OFS_PRESC   = 8'h08; // Prescaler
   localparam logic [7:0] OFS_TOP     = 8'h0c; // Counter end value
   localparam logic [7:0] OFS_REPS    = 8'h10; // Repetition count, 0 = continuous
   localparam logic [7:0] OFS_INIT    = 8'h14; // Starting level mask
   localparam logic [7:0] OFS_RESTORE = 8'h18; // Restore-on-expiry mask
   localparam logic [7:0] OFS_COUNT   = 8'h1c; // Live counter, read only
   localparam logic [7:0] OFS_CMP0    = 8'h20; // Comparator values, 0x20..0x3c
   localparam logic [7:0] OFS_LINK0   = 8'h40; // Per-output toggle masks, 0x40..0x5c
   localparam int unsigned DEC_W      = 8;     // Decoded address bits

   // ----------------------------------------------------------------------
   // Control and status register fields
   // ----------------------------------------------------------------------
   localparam int unsigned CTRL_OUT_EN = 0;    // Global output enable
   localparam int unsigned CTRL_IRQ_EN = 1;    // Completion interrupt enable
   localparam int unsigned CTRL_TRIG_LO = 2;   // Trigger mode, two bits
   localparam int unsigned CTRL_BLK_RST = 4;   // Write 1: block reset, reads 0
   localparam int unsigned STAT_DONE   = 0;    // Completion flag
   localparam int unsigned STAT_RUN    = 1;    // Counter running
   localparam int unsigned STAT_ARMED  = 2;    // Waiting for trigger edge

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [PRE_W-1:0] RST_PRESC = 8'h00;
   localparam logic [CNT_W-1:0] RST_TOP   = 16'h0000;
   localparam logic [REP_W-1:0] RST_REPS  = 8'h00;

   // Trigger selections
   typedef enum logic [1:0] {
      start_gate_off,
      start_on_rising_edge,
      start_on_falling_edge,
      start_on_any_edge
   } trig_mode_e;

   // Engine configuration carried from the register file
   typedef struct packed {
      logic                       out_en;
      trig_mode_e                 trig;
      logic [PRE_W-1:0]           presc;
      logic [CNT_W-1:0]           top;
      logic [REP_W-1:0]           reps;
      logic [NUM_OUT-1:0]         init;
      logic [NUM_OUT-1:0]         restore;
   } pwm_cfg_s;

endpackage

/* hw/pwm_trig_sync.sv */
// Trigger input synchroniser with edge selection
`timescale 1ns/1ps
module pwm_trig_sync (
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   input  wire logic              trig_i,   // Asynchronous trigger input
   input  wire pwm_pkg::trig_mode_e mode_i, // Selected edge kind
   output logic                   fire_o    // One-cycle pulse on selected edge
);

   // ----------------------------------------------------------------------
   // Synchroniser and edge detector
   // ----------------------------------------------------------------------
   logic s1_q;    // First stage, read only by second stage
   logic s2_q;    // Second stage, safe to use
   logic s3_q;    // Previous safe value for edges
   wire  rise = s2_q & ~s3_q;
   wire  fall = ~s2_q & s3_q;

   // Three-flop chain; edges come from stages two and three only
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= trig_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Edge selection
   always_comb begin
      unique case (mode_i)
         pwm_pkg::start_gate_off:        fire_o = 1'b0;
         pwm_pkg::start_on_rising_edge:  fire_o = rise;
         pwm_pkg::start_on_falling_edge: fire_o = fall;
         pwm_pkg::start_on_any_edge:     fire_o = rise | fall;
      endcase
   end

endmodule

/* hw/pwm_engine.sv */
// Counter, prescaler, comparators and output toggling of the modulator
`timescale 1ns/1ps
module pwm_engine #(
   parameter int unsigned NCMP = pwm_pkg::NUM_CMP,
   parameter int unsigned NOUT = pwm_pkg::NUM_OUT
) (
   input  wire logic                                  clk_i,
   input  wire logic                                  rstn_i,
   input  wire logic                                  clr_i,      // Block reset
   input  wire pwm_pkg::pwm_cfg_s                     cfg_i,      // Configuration
   input  wire logic [NCMP-1:0][pwm_pkg::CNT_W-1:0]   cmp_i,      // Comparator values
   input  wire logic [NOUT-1:0][NCMP-1:0]             link_i,     // Toggle masks
   input  wire logic                                  fire_i,     // Trigger edge
   output logic [NOUT-1:0]                            pwm_o,      // Output levels
   output logic [pwm_pkg::CNT_W-1:0]                  count_o,    // Live counter
   output logic                                       run_o,      // Running
   output logic                                       armed_o,    // Awaiting trigger
   output logic                                       done_o      // Completion pulse
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic [pwm_pkg::PRE_W-1:0] pre_q;   // Prescaler divider
   logic [pwm_pkg::CNT_W-1:0] cnt_q;   // Shared counter
   logic [pwm_pkg::REP_W-1:0] rep_q;   // Repetitions done
   logic [NOUT-1:0]           lvl_q;   // Output levels
   logic                      run_q;   // Counting
   logic                      fin_q;   // Finished, waits for enable to drop

   wire tick    = run_q && (pre_q == cfg_i.presc);     // Prescaled step
   wire at_top  = (cnt_q == cfg_i.top);
   wire expire  = tick && at_top;
   wire last    = (cfg_i.reps != '0) && (rep_q == cfg_i.reps - 8'h01);
   wire gated   = (cfg_i.trig != pwm_pkg::start_gate_off);
   wire start   = cfg_i.out_en && !run_q && !fin_q && (!gated || fire_i);

   // Which comparators match on this step
   logic [NCMP-1:0] hit;
   logic [NOUT-1:0] flip;
   always_comb begin
      for (int c = 0; c < NCMP; c++) begin
         hit[c] = tick && (cmp_i[c] == cnt_q);
      end
      for (int o = 0; o < NOUT; o++) begin
         flip[o] = |(hit & link_i[o]);
      end
   end

   // Prescaler and counter
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pre_q <= '0;
         cnt_q <= '0;
         rep_q <= '0;
         run_q <= 1'b0;
         fin_q <= 1'b0;
      end else if (clr_i || !cfg_i.out_en) begin
         pre_q <= '0;
         cnt_q <= '0;
         rep_q <= '0;
         run_q <= 1'b0;
         fin_q <= 1'b0;
      end else begin
         pre_q <= (!run_q || tick) ? '0 : pre_q + 8'h01;
         if (start) begin
            run_q <= 1'b1;
            cnt_q <= '0;
         end else if (expire) begin
            cnt_q <= '0;
            if (last) begin
               run_q <= 1'b0;
               fin_q <= 1'b1;
            end
            rep_q <= last ? '0 : rep_q + 8'h01;
         end else if (tick) begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end

   // Output levels: start level, toggles, restore on expiry
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lvl_q <= '0;
      end else if (clr_i) begin
         lvl_q <= '0;
      end else if (!run_q) begin
         lvl_q <= cfg_i.init;
      end else if (expire) begin
         lvl_q <= (cfg_i.restore & cfg_i.init) | (~cfg_i.restore & (lvl_q ^ flip));
      end else begin
         lvl_q <= lvl_q ^ flip;
      end
   end

   // Registered outputs; pins low unless enabled and not in block reset
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pwm_o   <= '0;
         count_o <= '0;
         run_o   <= 1'b0;
         armed_o <= 1'b0;
         done_o  <= 1'b0;
      end else begin
         pwm_o   <= (cfg_i.out_en && !clr_i) ? lvl_q : '0;
         count_o <= cnt_q;
         run_o   <= run_q;
         armed_o <= cfg_i.out_en && !run_q && !fin_q && gated;
         done_o  <= expire && last && !clr_i;
      end
   end

endmodule

/* hw/pwm_top.sv */
// Multi-channel comparator-toggle pulse modulator with AHB-Lite register slave
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module pwm_top #(
   parameter int unsigned NCMP = pwm_pkg::NUM_CMP,
   parameter int unsigned NOUT = pwm_pkg::NUM_OUT
) (
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   // AHB-Lite slave
   input  wire logic              hsel_i,
   input  wire logic [31:0]       haddr_i,
   input  wire logic [1:0]        htrans_i,
   input  wire logic              hwrite_i,
   input  wire logic [2:0]        hsize_i,
   input  wire logic [31:0]       hwdata_i,
   input  wire logic              hready_i,
   output logic [31:0]            hrdata_o,
   output logic                   hreadyout_o,
   output logic                   hresp_o,
   // Trigger and outputs
   input  wire logic              trig_i,     // Asynchronous trigger input
   output logic [NOUT-1:0]        pwm_o,      // Modulated outputs
   output logic                   irq_o       // Completion interrupt, level
);

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   logic                                 out_en_q;   // Global output enable
   logic                                 irq_en_q;   // Completion interrupt enable
   pwm_pkg::trig_mode_e                  trig_q;     // Trigger mode
   logic [pwm_pkg::PRE_W-1:0]            presc_q;    // Prescaler
   logic [pwm_pkg::CNT_W-1:0]            top_q;      // Counter end value
   logic [pwm_pkg::REP_W-1:0]            reps_q;     // Repetition count
   logic [NOUT-1:0]                      init_q;     // Start levels
   logic [NOUT-1:0]                      rest_q;     // Restore mask
   logic [NCMP-1:0][pwm_pkg::CNT_W-1:0]  cmp_q;      // Comparator values
   logic [NOUT-1:0][NCMP-1:0]            link_q;     // Toggle masks
   logic                                 done_q;     // Sticky completion flag
   logic                                 clr_q;      // Block reset pulse

   // ----------------------------------------------------------------------
   // AHB-Lite address phase capture
   // ----------------------------------------------------------------------
   logic                      wr_q;     // Write pending in data phase
   logic                      rd_q;     // Read pending in data phase
   logic [pwm_pkg::DEC_W-1:0] addr_q;   // Captured byte address

   // Transfers are taken only when the bus is ready and the slot is NONSEQ/SEQ
   wire take   = hsel_i && hready_i && htrans_i[1];
   wire wr_ph  = wr_q;

   // Register select wires for the data phase
   wire sel_ctrl  = (addr_q == pwm_pkg::OFS_CTRL);
   wire sel_stat  = (addr_q == pwm_pkg::OFS_STATUS);
   wire sel_presc = (addr_q == pwm_pkg::OFS_PRESC);
   wire sel_top   = (addr_q == pwm_pkg::OFS_TOP);
   wire sel_reps  = (addr_q == pwm_pkg::OFS_REPS);
   wire sel_init  = (addr_q == pwm_pkg::OFS_INIT);
   wire sel_rest  = (addr_q == pwm_pkg::OFS_RESTORE);
   wire sel_cnt   = (addr_q == pwm_pkg::OFS_COUNT);
   wire sel_cmp   = (addr_q[7:5] == pwm_pkg::OFS_CMP0[7:5]);
   wire sel_link  = (addr_q[7:5] == pwm_pkg::OFS_LINK0[7:5]);
   wire [2:0] idx = addr_q[4:2];                       // Comparator or output index

   // Engine status
   logic [pwm_pkg::CNT_W-1:0] count;
   logic                      run;
   logic                      armed;
   logic                      done_pulse;
   logic                      fire;

   // Address phase latch; unmapped addresses read zero and ignore writes
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= '0;
      end else if (hready_i) begin
         wr_q   <= take && hwrite_i;
         rd_q   <= take && !hwrite_i;
         addr_q <= haddr_i[pwm_pkg::DEC_W-1:0];
      end
   end

   // ----------------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------------
   // Block reset is a self-clearing command bit; it also wipes the whole map
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_en_q <= 1'b0;
         irq_en_q <= 1'b0;
         trig_q   <= pwm_pkg::start_gate_off;
         presc_q  <= pwm_pkg::RST_PRESC;
         top_q    <= pwm_pkg::RST_TOP;
         reps_q   <= pwm_pkg::RST_REPS;
         init_q   <= '0;
         rest_q   <= '0;
         cmp_q    <= '0;
         link_q   <= '0;
         clr_q    <= 1'b0;
      end else if (clr_q) begin
         out_en_q <= 1'b0;
         irq_en_q <= 1'b0;
         trig_q   <= pwm_pkg::start_gate_off;
         presc_q  <= pwm_pkg::RST_PRESC;
         top_q    <= pwm_pkg::RST_TOP;
         reps_q   <= pwm_pkg::RST_REPS;
         init_q   <= '0;
         rest_q   <= '0;
         cmp_q    <= '0;
         link_q   <= '0;
         clr_q    <= 1'b0;
      end else if (wr_ph) begin
         if (sel_ctrl) begin
            out_en_q <= hwdata_i[pwm_pkg::CTRL_OUT_EN];
            irq_en_q <= hwdata_i[pwm_pkg::CTRL_IRQ_EN];
            trig_q   <= pwm_pkg::trig_mode_e'(hwdata_i[pwm_pkg::CTRL_TRIG_LO +: 2]);
            clr_q    <= hwdata_i[pwm_pkg::CTRL_BLK_RST];
         end
         if (sel_presc) presc_q <= hwdata_i[pwm_pkg::PRE_W-1:0];
         if (sel_top)   top_q   <= hwdata_i[pwm_pkg::CNT_W-1:0];
         if (sel_reps)  reps_q  <= hwdata_i[pwm_pkg::REP_W-1:0];
         if (sel_init)  init_q  <= hwdata_i[NOUT-1:0];
         if (sel_rest)  rest_q  <= hwdata_i[NOUT-1:0];
         if (sel_cmp)   cmp_q[idx]  <= hwdata_i[pwm_pkg::CNT_W-1:0];
         if (sel_link)  link_q[idx] <= hwdata_i[NCMP-1:0];
      end
   end

   // Sticky completion flag: write 1 clears, a new completion wins the tie
   wire done_clr = wr_ph && sel_stat && hwdata_i[pwm_pkg::STAT_DONE];
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         done_q <= 1'b0;
      end else if (done_pulse && !clr_q) begin
         done_q <= 1'b1;
      end else if (done_clr || clr_q) begin
         done_q <= 1'b0;
      end
   end

   // Interrupt line: flag gated by the interrupt enable
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= irq_en_q && (done_q || done_pulse) && !clr_q;
      end
   end

   // ----------------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------------
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      if (sel_ctrl) begin
         rmux[pwm_pkg::CTRL_OUT_EN]         = out_en_q;
         rmux[pwm_pkg::CTRL_IRQ_EN]         = irq_en_q;
         rmux[pwm_pkg::CTRL_TRIG_LO +: 2]   = trig_q;
      end
      if (sel_stat) begin
         rmux[pwm_pkg::STAT_DONE]  = done_q;
         rmux[pwm_pkg::STAT_RUN]   = run;
         rmux[pwm_pkg::STAT_ARMED] = armed;
      end
      if (sel_presc) rmux[pwm_pkg::PRE_W-1:0] = presc_q;
      if (sel_top)   rmux[pwm_pkg::CNT_W-1:0] = top_q;
      if (sel_reps)  rmux[pwm_pkg::REP_W-1:0] = reps_q;
      if (sel_init)  rmux[NOUT-1:0]           = init_q;
      if (sel_rest)  rmux[NOUT-1:0]           = rest_q;
      if (sel_cnt)   rmux[pwm_pkg::CNT_W-1:0] = count;
      if (sel_cmp)   rmux[pwm_pkg::CNT_W-1:0] = cmp_q[idx];
      if (sel_link)  rmux[NCMP-1:0]           = link_q[idx];
   end

   // Read data is registered, so a read takes one wait state
   logic rd_wait_q;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hrdata_o    <= '0;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
         rd_wait_q   <= 1'b0;
      end else begin
         hresp_o <= 1'b0;
         if (rd_q && !rd_wait_q) begin
            hrdata_o    <= rmux;
            hreadyout_o <= 1'b1;
            rd_wait_q   <= 1'b1;
         end else if (take && !hwrite_i) begin
            hreadyout_o <= 1'b0;  // Hold master until data is registered
            rd_wait_q   <= 1'b0;
         end else begin
            hreadyout_o <= 1'b1;
            rd_wait_q   <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Engine and trigger
   // ----------------------------------------------------------------------
   pwm_pkg::pwm_cfg_s cfg;
   assign cfg = '{out_en: out_en_q, trig: trig_q, presc: presc_q, top: top_q,
                  reps: reps_q, init: init_q, restore: rest_q};

   pwm_trig_sync u_trig (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .trig_i (trig_i),
      .mode_i (trig_q),
      .fire_o (fire)
   );

   pwm_engine #(
      .NCMP (NCMP),
      .NOUT (NOUT)
   ) u_eng (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .clr_i   (clr_q),
      .cfg_i   (cfg),
      .cmp_i   (cmp_q),
      .link_i  (link_q),
      .fire_i  (fire),
      .pwm_o   (pwm_o),
      .count_o (count),
      .run_o   (run),
      .armed_o (armed),
      .done_o  (done_pulse)
   );

endmodule

/* sim/pwm_top_properties.sv */
// Checker of bus timing, output gating and interrupt rules of the modulator
`timescale 1ns/1ps
module pwm_top_checker #(
   parameter int unsigned NCMP = 8,
   parameter int unsigned NOUT = 8
) (
   input wire logic            clk_i,
   input wire logic            rstn_i,
   input wire logic            hsel_i,
   input wire logic [31:0]     haddr_i,
   input wire logic [1:0]      htrans_i,
   input wire logic            hwrite_i,
   input wire logic [31:0]     hwdata_i,
   input wire logic            hready_i,
   input wire logic            hreadyout_o,
   input wire logic            hresp_o,
   input wire logic [NOUT-1:0] pwm_o,
   input wire logic            irq_o
);
   // -----------------------------------------------------------------
   // Shadow of the enables, taken from each write data phase
   // -----------------------------------------------------------------
   wire logic       take = hsel_i && hready_i && htrans_i[1];
   logic            wr_q, wr1_q, wr2_q; // Write data phase and its history
   logic [7:0]      a_q;                // Address of that write
   logic            en_q, ie_q, reps_q; // Output enable, irq enable, finite run
   logic [1:0]      off_q;              // Cycles since output enable dropped
   wire logic       ctl_wr = wr_q && a_q == pwm_pkg::OFS_CTRL;
   // Bus phase tracking; writes have no wait state
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {wr_q, wr1_q, wr2_q, a_q} <= '0;
      end else begin
         {wr_q, wr1_q, wr2_q, a_q} <= {take && hwrite_i, wr_q, wr1_q, haddr_i[7:0]};
      end
   end
   // Block reset wins over the enable bits written with it
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {en_q, ie_q, reps_q} <= '0;
      end else if (ctl_wr) begin
         {en_q, ie_q, reps_q} <= hwdata_i[4] ? 3'h0 : {hwdata_i[0], hwdata_i[1], reps_q};
      end else if (wr_q && a_q == pwm_pkg::OFS_REPS) begin
         reps_q <= |hwdata_i[7:0];
      end
   end
   // Saturating count, so the output lag is allowed for
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         off_q <= 2'h0;
      end else begin
         off_q <= en_q ? 2'h0 : off_q + 2'(off_q != 2'h3);
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   chk_resp_okay: assert property (hresp_o == 1'b0)
      else $error("slave response is not OKAY");
   chk_write_no_wait: assert property (take && hwrite_i |=> hreadyout_o)
      else $error("write data phase stretched");
   chk_read_one_wait: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
      else $error("read answer not after one wait state");
   chk_out_off_zero: assert property (off_q == 2'h3 |-> pwm_o == '0)
      else $error("outputs driven while disabled");
   chk_irq_masked: assert property ($rose(irq_o) |-> ie_q)
      else $error("interrupt raised while its enable is clear");
   chk_cont_no_irq: assert property ($rose(irq_o) |-> reps_q)
      else $error("interrupt raised in continuous running");
   chk_blk_reset_clear: assert property (ctl_wr && hwdata_i[4] |-> ##[1:3] (pwm_o == '0 && !irq_o))
      else $error("block reset left outputs or interrupt up");
   chk_irq_level_holds: assert property (irq_o && !wr_q && !wr1_q && !wr2_q |=> irq_o)
      else $error("interrupt dropped without a write");
endmodule
bind pwm_top pwm_top_checker #(.NCMP(NCMP), .NOUT(NOUT)) chk_inst (
   .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
   .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pwm_o(pwm_o), .irq_o(irq_o));

/* sim/pwm_load_model.sv */
// Model of the loads on the modulated outputs: counts rising edges
`timescale 1ns/1ps
module pwm_load_model #(
   parameter int unsigned NOUT = 8
) (
   input  wire logic            clk_i,
   input  wire logic            clr_i,   // Restart the counts
   input  wire logic [NOUT-1:0] pwm_i,   // Levels seen at the loads
   output int                   rises_o [NOUT]
);
   logic [NOUT-1:0] last_q = '0; // Known start, so no edge at time zero
   // Edge counting, one count per output
   always @(posedge clk_i) begin
      last_q <= pwm_i;
      for (int i = 0; i < NOUT; i++) begin
         if (clr_i) rises_o[i] <= 0;
         else if (pwm_i[i] && !last_q[i]) rises_o[i] <= rises_o[i] + 1;
      end
   end
endmodule

/* sim/comparator_toggle_pwm_block_test.sv */
// Self-checking bench of the pulse modulator
`timescale 1ns/1ps
module comparator_toggle_pwm_block_test;
   localparam int TOP = 9;  // Short end value keeps the run brief
   localparam int REPS = 4; // Even count so out 1 ends on its start level
   logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, trig = 1'b0, clr = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, d;
   logic [1:0]  htrans = 2'h0;
   logic        hrdy, hresp, irq;
   logic [7:0]  pwm;
   int          failures = 0, n_tests = 0, seed = 19, n;
   int          rises [8];
   int          cv [8] = '{2, 5, 5, 7, 0, 0, 0, 0};   // Comparator values
   logic [7:0]  lk [8] = '{8'h01, 8'h06, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0]  zo [11] = '{pwm_pkg::OFS_CTRL, pwm_pkg::OFS_STATUS, pwm_pkg::OFS_PRESC,
      pwm_pkg::OFS_TOP, pwm_pkg::OFS_REPS, pwm_pkg::OFS_INIT, pwm_pkg::OFS_RESTORE,
      pwm_pkg::OFS_COUNT, pwm_pkg::OFS_CMP0, pwm_pkg::OFS_LINK0, 8'h80};
   always #2.5 clk = ~clk;
   pwm_top dut (.clk_i(clk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
      .hreadyout_o(hrdy), .hresp_o(hresp), .trig_i(trig), .pwm_o(pwm), .irq_o(irq));
   pwm_load_model load (.clk_i(clk), .clr_i(clr), .pwm_i(pwm), .rises_o(rises));
   // -----------------------------------------------------------------
   // Bus tasks, comparison and verdict
   // -----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One single transfer; address held until ready, data taken at last edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'h2, w};
      do @(posedge clk); while (hrdy !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, v};
      do @(posedge clk); while (hrdy !== 1'b1);
      d = hrdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(d, exp);
   endtask
   task automatic zero_regs;
      foreach (zo[i]) rdc(zo[i], 32'h0);
   endtask
   // Level walk of one output over all runs, restore winning at expiry
   function automatic int model_rises(logic ini, logic rs, logic [7:0] lnk);
      int   k;
      logic lv, nl, t;
      k = int'(ini);
      lv = ini;
      for (int r = 0; r < REPS; r++) begin
         for (int c = 0; c <= TOP; c++) begin
            t = 1'b0;
            for (int j = 0; j < 8; j++) if (lnk[j] && cv[j] == c) t = 1'b1;
            nl = (c == TOP && rs) ? ini : lv ^ t;
            if (nl && !lv) k++;
            lv = nl;
         end
      end
      return k;
   endfunction
   task automatic tally_and_finish;
      if (failures == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Hang guard, far beyond the fewer than a thousand cycles the run needs
   initial begin
      #100000;
      failures++;
      tally_and_finish();
   end
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      zero_regs();
      for (int i = 0; i < 8; i++) begin
         n = $random(seed);
         xfer(1'b1, pwm_pkg::OFS_CMP0 + 8'(4 * i), n);
         rdc(pwm_pkg::OFS_CMP0 + 8'(4 * i), n & 32'hffff);
         xfer(1'b1, pwm_pkg::OFS_LINK0 + 8'(4 * i), ~n);
         rdc(pwm_pkg::OFS_LINK0 + 8'(4 * i), ~n & 32'hff);
         xfer(1'b1, pwm_pkg::OFS_CMP0 + 8'(4 * i), cv[i]);
         xfer(1'b1, pwm_pkg::OFS_LINK0 + 8'(4 * i), 32'(lk[i]));
      end
      xfer(1'b1, pwm_pkg::OFS_PRESC, 32'h1);
      xfer(1'b1, pwm_pkg::OFS_TOP, TOP);
      xfer(1'b1, pwm_pkg::OFS_REPS, REPS);
      xfer(1'b1, pwm_pkg::OFS_INIT, 32'h2);
      xfer(1'b1, pwm_pkg::OFS_RESTORE, 32'h1);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      xfer(1'b1, pwm_pkg::OFS_CTRL, 32'h3);
      n = 0;
      while (irq !== 1'b1 && n < 500) begin
         @(posedge clk);
         n++;
      end
      check(32'(n >= 75 && n <= 95), 32'h1);
      for (int o = 0; o < 8; o++) check(rises[o], model_rises(o == 1, o == 0, lk[o]));
      rdc(pwm_pkg::OFS_STATUS, 32'h1);
      xfer(1'b1, pwm_pkg::OFS_STATUS, 32'h1);
      repeat (3) @(posedge clk);
      check(32'(irq), 32'h0);
      xfer(1'b1, pwm_pkg::OFS_CTRL, 32'h0);
      repeat (4) @(posedge clk);
      check(32'(pwm), 32'h0);
      xfer(1'b1, pwm_pkg::OFS_REPS, 32'h1);
      xfer(1'b1, pwm_pkg::OFS_CTRL, 32'h1);
      repeat (40) @(posedge clk);
      check(32'(irq), 32'h0);
      rdc(pwm_pkg::OFS_STATUS, 32'h1);
      xfer(1'b1, pwm_pkg::OFS_STATUS, 32'h1);
      xfer(1'b1, pwm_pkg::OFS_REPS, 32'h0);
      for (int m = 1; m < 4; m++) begin
         trig <= (m == 2);
         xfer(1'b1, pwm_pkg::OFS_CTRL, 32'h0);
         repeat (8) @(posedge clk);
         xfer(1'b1, pwm_pkg::OFS_CTRL, 32'(1 + 4 * m));
         repeat (8) @(posedge clk);
         rdc(pwm_pkg::OFS_STATUS, 32'h4);
         trig <= (m != 2);
         repeat (8) @(posedge clk);
         rdc(pwm_pkg::OFS_STATUS, 32'h2);
      end
      repeat (100) @(posedge clk);
      rdc(pwm_pkg::OFS_STATUS, 32'h2);
      xfer(1'b1, 8'h80, 32'hffffffff);
      xfer(1'b1, pwm_pkg::OFS_CTRL, 32'h10);
      repeat (3) @(posedge clk);
      check(32'(pwm), 32'h0);
      zero_regs();
      tally_and_finish();
   end
endmodule
